//--- hdl/sep_eeprom.sv
`timescale 1ns/100ps
// Summary of operation
// - Protect bits pick none, quarter, half, all.
// - Protect bits stored, written by timed cycle.
// - Status write also sets pin enable bit.
// - Hardware protected when pin low, enable set.
// - Pin high or enable clear: no hardware protection.
// - Hardware protected refuses every status write.
// - Enable bit stays set while pin low.
// - Protected region refuses array writes always.
// - Write with latch clear is ignored.
// - During write cycle only status read works.
// - Read opcode, address, then data MSB first.
// - Input ignored after read address received.
// - Read address increments, bytes keep coming.
// - Read address wraps to zero past top.
// - Programming starts only after select rises.
// - Status bit zero shows busy.
// - Page write increments six low bits only.
// - Page address wraps inside 64-byte page.
// - Write cycle end clears the latch.
// - Opcodes decoded with bit three ignored.
// - Transfers MSB first, start on select fall.
// - Status layout; all ones while busy.
// - Bad opcode: ignore input, output stays off.
module sep_eeprom
   import sep_pkg::*;
#(
   parameter int AW = 14,
   parameter int WRITE_TIME = sep_pkg::WRITE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sck,
   input wire logic sel_n,
   input wire logic si,
   input wire logic wp_n,
   output logic so,
   output logic so_oe,
   output logic busy_out
);
   import sep_pkg::*;
   localparam int DEPTH = 1 << AW;
   localparam int PAGE = 1 << PAGE_BITS;

   // ==========================================================
   // Pin synchronisation and edge detection
   logic [3:0] pins;
   logic sck_d, sel_d;
   sep_sync #(.W(4), .RST_VAL(4'h5)) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .d({sck, sel_n, si, wp_n}),
      .q(pins)
   );
   wire sck_s = pins[3];
   wire sel_s = pins[2];
   wire si_s = pins[1];
   wire wp_s = pins[0];
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sck_d <= 1'b0;
         sel_d <= 1'b1;
      end else begin
         sck_d <= sck_s;
         sel_d <= sel_s;
      end
   end
   wire sck_rise = sck_s && !sck_d && !sel_s;
   wire sck_fall = !sck_s && sck_d && !sel_s;
   wire sel_fall = !sel_s && sel_d;
   wire sel_rise = sel_s && !sel_d;

   // ==========================================================
   // Storage and protection
   logic [7:0] mem [DEPTH];
   logic [7:0] page_buf [PAGE];
   logic [PAGE-1:0] page_vld;
   sep_prot_t prot, prot_pend;
   logic wlatch;
   logic tm_start, tm_busy, tm_done;
   logic pend_arr, pend_stat;
   logic [AW-1:0] page_base;

   function automatic logic addr_protected(input logic [AW-1:0] a, input sep_prot_t p);
      logic [1:0] top;
      top = a[AW-1 -: 2];
      case ({p.bp_hi, p.bp_lo})
         2'b01: addr_protected = (top == 2'b11);
         2'b10: addr_protected = top[1];
         2'b11: addr_protected = 1'b1;
         default: addr_protected = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] opc_norm(input logic [7:0] b);
      opc_norm = b & CMD_MASK;
   endfunction

   wire hw_prot = !wp_s && prot.ppe;

   sep_timer #(.CYCLES(WRITE_TIME)) u_timer (
      .clk_sys(clk_sys),
      .rst(rst),
      .start(tm_start),
      .busy(tm_busy),
      .done(tm_done)
   );

   // ==========================================================
   // Serial command engine
   sep_state_t state;
   logic [7:0] shreg;
   logic [2:0] bitcnt;
   logic [ADDR_FIELD_W-1:0] addr_sh;
   logic addr_half;
   logic [7:0] opc;
   logic [AW-1:0] addr;
   logic [7:0] tx;
   logic drive;

   wire [7:0] status_now = tm_busy ? ST_ALL_ONES :
      {prot.ppe, 3'b000, prot.bp_hi, prot.bp_lo, wlatch, 1'b0};
   wire [7:0] rx_byte = {shreg[6:0], si_s};
   wire byte_done = sck_rise && (bitcnt == 3'h7);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= SEP_IDLE;
         shreg <= 8'h00;
         bitcnt <= 3'h0;
         addr_sh <= '0;
         addr_half <= 1'b0;
         opc <= 8'h00;
         addr <= '0;
         tx <= 8'h00;
         drive <= 1'b0;
         wlatch <= 1'b0;
         pend_arr <= 1'b0;
         pend_stat <= 1'b0;
         prot_pend <= '0;
         page_vld <= '0;
         page_base <= '0;
         tm_start <= 1'b0;
      end else begin
         tm_start <= 1'b0;
         // Pending work lives until the cycle ends, so status polls in between keep it.
         if (tm_done) begin
            wlatch <= 1'b0;
            pend_arr <= 1'b0;
            pend_stat <= 1'b0;
            page_vld <= '0;
         end
         if (sel_fall) begin
            state <= SEP_OPC;
            bitcnt <= 3'h0;
            addr_half <= 1'b0;
            drive <= 1'b0;
         end else if (sel_rise) begin
            state <= SEP_IDLE;
            drive <= 1'b0;
            // Only a whole byte boundary starts programming.
            if ((pend_arr || pend_stat) && bitcnt == 3'h0 && !tm_busy && !tm_done) begin
               tm_start <= 1'b1;
            end else if (!tm_busy && !tm_done) begin
               pend_arr <= 1'b0;
               pend_stat <= 1'b0;
               page_vld <= '0;
            end
         end else if (sck_rise) begin
            bitcnt <= bitcnt + 3'h1;
            shreg <= rx_byte;
            if (byte_done) begin
               case (state)
                  SEP_OPC: begin
                     opc <= opc_norm(rx_byte);
                     if (tm_busy && opc_norm(rx_byte) != CMD_RD_STAT) begin
                        state <= SEP_IDLE;
                     end else begin
                        case (opc_norm(rx_byte))
                           CMD_SET_WL: begin
                              wlatch <= 1'b1;
                              state <= SEP_IDLE;
                           end
                           CMD_CLR_WL: begin
                              wlatch <= 1'b0;
                              state <= SEP_IDLE;
                           end
                           CMD_RD_STAT: begin
                              state <= SEP_STAT_RD;
                           end
                           CMD_WR_STAT: begin
                              state <= wlatch ? SEP_STAT_WR : SEP_IDLE;
                           end
                           CMD_RD_ARR: begin
                              state <= SEP_ADDR;
                           end
                           CMD_WR_ARR: begin
                              state <= wlatch ? SEP_ADDR : SEP_IDLE;
                           end
                           default: begin
                              state <= SEP_IDLE;
                           end
                        endcase
                     end
                  end
                  SEP_ADDR: begin
                     addr_sh <= {addr_sh[7:0], rx_byte};
                     addr_half <= 1'b1;
                     if (addr_half) begin
                        addr <= AW'({addr_sh[7:0], rx_byte});
                        page_base <= AW'({addr_sh[7:0], rx_byte});
                        state <= (opc == CMD_RD_ARR) ? SEP_RDATA : SEP_WDATA;
                     end
                  end
                  SEP_WDATA: begin
                     if (!addr_protected(addr, prot)) begin
                        page_buf[addr[PAGE_BITS-1:0]] <= rx_byte;
                        page_vld[addr[PAGE_BITS-1:0]] <= 1'b1;
                        pend_arr <= 1'b1;
                     end
                     addr[PAGE_BITS-1:0] <= addr[PAGE_BITS-1:0] + PAGE_BITS'(1);
                  end
                  SEP_STAT_WR: begin
                     if (!hw_prot) begin
                        prot_pend <= '{ppe: rx_byte[ST_PPE], bp_hi: rx_byte[ST_BPHI],
                           bp_lo: rx_byte[ST_BPLO]};
                        pend_stat <= 1'b1;
                     end
                     state <= SEP_IDLE;
                  end
                  default: begin
                  end
               endcase
            end
         end else if (sck_fall) begin
            // read phases never look at serial input.
            if (state == SEP_RDATA || state == SEP_STAT_RD) begin
               drive <= 1'b1;
               if (bitcnt == 3'h0) begin
                  tx <= (state == SEP_RDATA) ? mem[addr] : status_now;
                  if (state == SEP_RDATA) begin
                     addr <= addr + AW'(1);
                  end
               end else begin
                  tx <= {tx[6:0], 1'b0};
               end
            end
         end
      end
   end

   // ==========================================================
   // Nonvolatile commit at the end of the timed cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prot <= '0;
      end else if (tm_done && pend_stat) begin
         // Pin enable cannot clear while the pin holds protection.
         prot <= '{ppe: (prot.ppe && !wp_s) | prot_pend.ppe, bp_hi: prot_pend.bp_hi,
            bp_lo: prot_pend.bp_lo};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (tm_done && pend_arr) begin
         for (int i = 0; i < PAGE; i++) begin
            if (page_vld[i]) begin
               mem[{page_base[AW-1:PAGE_BITS], PAGE_BITS'(i)}] <= page_buf[i];
            end
         end
      end
   end

   // ==========================================================
   // Outputs
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         so <= 1'b0;
         so_oe <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         so <= tx[7];
         so_oe <= drive && !sel_s;
         busy_out <= tm_busy;
      end
   end

   // ==========================================================
   // Checks
   property p_busy_status;
      @(posedge clk_sys) disable iff (rst) (tm_busy && sck_fall && state == SEP_STAT_RD && bitcnt == 3'h0) |=> &tx;
   endproperty
   a_busy_status: assert property (p_busy_status) else $error("status not all ones while busy");

   property p_latch_clear;
      @(posedge clk_sys) disable iff (rst) (tm_done && !byte_done) |=> !wlatch;
   endproperty
   a_latch_clear: assert property (p_latch_clear) else $error("latch kept after write cycle");

   property p_hw_prot;
      @(posedge clk_sys) disable iff (rst) (!wp_s && prot.ppe && byte_done && state == SEP_STAT_WR) |=> !pend_stat;
   endproperty
   a_hw_prot: assert property (p_hw_prot) else $error("hardware protection missing");

   property p_no_prot;
      @(posedge clk_sys) disable iff (rst) ((wp_s || !prot.ppe) && byte_done && state == SEP_STAT_WR) |=> pend_stat;
   endproperty
   a_no_prot: assert property (p_no_prot) else $error("hardware protection spurious");

   property p_ppe_hold;
      @(posedge clk_sys) disable iff (rst) (prot.ppe && !wp_s) |=> prot.ppe;
   endproperty
   a_ppe_hold: assert property (p_ppe_hold) else $error("enable cleared while pin low");

   property p_start_on_rise;
      @(posedge clk_sys) disable iff (rst) tm_start |-> $past(sel_rise);
   endproperty
   a_start_on_rise: assert property (p_start_on_rise) else $error("write began without select rise");

   property p_busy_bit;
      @(posedge clk_sys) disable iff (rst) (!tm_busy && sck_fall && state == SEP_STAT_RD) |=> !tx[ST_BUSY];
   endproperty
   a_busy_bit: assert property (p_busy_bit) else $error("busy bit set when idle");

   property p_idle_quiet;
      @(posedge clk_sys) disable iff (rst) (state == SEP_IDLE) ##1 (state == SEP_IDLE) |=> !drive;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("output driven when idle");

   property p_busy_ignores;
      @(posedge clk_sys) disable iff (rst) (tm_busy && byte_done && state == SEP_OPC
         && opc_norm(rx_byte) != CMD_RD_STAT) |=> state == SEP_IDLE;
   endproperty
   a_busy_ignores: assert property (p_busy_ignores) else $error("command taken during write");
endmodule

//--- common/sep_pkg.sv
package sep_pkg;
   localparam int ADDR_FIELD_W = 16;
   localparam int PAGE_BITS = 6;
   localparam logic [7:0] CMD_MASK = 8'hF7;
   localparam logic [7:0] CMD_SET_WL = 8'h06;
   localparam logic [7:0] CMD_CLR_WL = 8'h04;
   localparam logic [7:0] CMD_RD_STAT = 8'h05;
   localparam logic [7:0] CMD_WR_STAT = 8'h01;
   localparam logic [7:0] CMD_RD_ARR = 8'h03;
   localparam logic [7:0] CMD_WR_ARR = 8'h02;
   localparam int ST_PPE = 7;
   localparam int ST_BPHI = 3;
   localparam int ST_BPLO = 2;
   localparam int ST_WL = 1;
   localparam int ST_BUSY = 0;
   localparam logic [7:0] ST_ALL_ONES = 8'hFF;
   localparam real CLK_NS = 100.0;
   localparam real WRITE_CYCLE_MS = 5.0;
   localparam int WRITE_CYCLES = int'(WRITE_CYCLE_MS * 1.0e6 / CLK_NS);
   typedef enum logic [2:0] {SEP_OPC, SEP_ADDR, SEP_RDATA, SEP_WDATA, SEP_STAT_RD, SEP_STAT_WR, SEP_IDLE} sep_state_t;
   typedef struct packed {
      logic ppe;
      logic bp_hi;
      logic bp_lo;
   } sep_prot_t;
endpackage

//--- hdl/sep_sync.sv
`timescale 1ns/100ps
module sep_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   // The first stage feeds only the second.
   // Resetting to the idle level of each pin avoids a false edge after reset.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

//--- hdl/sep_timer.sv
`timescale 1ns/100ps
module sep_timer #(
   parameter int CYCLES = 50000
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic start,
   output logic busy,
   output logic done
);
   logic [31:0] count;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count <= 32'h0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy <= 1'b1;
            count <= 32'(CYCLES - 1);
         end else if (busy) begin
            if (count == 32'h0) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               count <= count - 32'h1;
            end
         end
      end
   end
endmodule

//--- sim/sep_master.sv
`timescale 1ns/100ps
// ==========================================
// Serial master model.
// The link clock stands low between frames; input data toggles once released.
module sep_master (
   input wire logic clk_sys,
   output logic sck,
   output logic sel_n,
   output logic si,
   input wire logic so,
   input wire logic so_oe,
   output logic oe_seen
);
   initial begin
      sck = 1'b0;
      sel_n = 1'b1;
      si = 1'b0;
      oe_seen = 1'b0;
   end

   always @(posedge clk_sys) begin
      if (!sel_n && so_oe) begin
         oe_seen <= 1'b1;
      end
   end

   // Bytes past the end of tx carry a changing junk pattern on purpose.
   task automatic frame(input logic [7:0] tx [$], input int nbytes, output logic [7:0] rx [$]);
      logic [7:0] b;
      logic [7:0] r;
      rx = {};
      @(posedge clk_sys);
      oe_seen <= 1'b0;
      sel_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      for (int i = 0; i < nbytes; i++) begin
         b = (i < tx.size()) ? tx[i] : (8'hA5 ^ 8'(i));
         for (int k = 7; k >= 0; k--) begin
            si <= b[k];
            repeat (4) @(posedge clk_sys);
            sck <= 1'b1;
            repeat (2) @(posedge clk_sys);
            // A released output reads as the inverse, so only a driven bit can match.
            r[k] = so_oe ? so : ~so;
            repeat (2) @(posedge clk_sys);
            sck <= 1'b0;
         end
         rx.push_back(r);
      end
      repeat (2) @(posedge clk_sys);
      sel_n <= 1'b1;
      si <= ~si;
      repeat (8) @(posedge clk_sys);
   endtask
endmodule

//--- sim/sep_eeprom_tb_top.sv
`timescale 1ns/100ps
module sep_eeprom_tb_top;
   import sep_pkg::*;
   // Long enough that a whole command frame fits inside one write cycle.
   localparam int WT = 500;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic wp_n = 1'b1;
   logic sck, sel_n, si, so, so_oe, busy_out, oe_seen;
   int n_fail = 0;
   int comparisons = 0;
   logic [7:0] rx [$];
   logic [7:0] st;
   logic [7:0] dq [$];
   logic [15:0] prot [1:3] = '{16'h3000, 16'h2000, 16'h0000};
   logic [7:0] old [1:3] = '{8'h30, 8'h20, 8'h11};

   always #50 clk_sys = ~clk_sys;

   sep_eeprom #(.AW(14), .WRITE_TIME(WT)) u_dut (.clk_sys(clk_sys), .rst(rst), .sck(sck), .sel_n(sel_n),
      .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe), .busy_out(busy_out));
   sep_master u_master (.clk_sys(clk_sys), .sck(sck), .sel_n(sel_n), .si(si), .so(so), .so_oe(so_oe),
      .oe_seen(oe_seen));

   // ==========================================
   // Access tasks.
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rd_status(input logic [7:0] x3 = 8'h00);
      u_master.frame({CMD_RD_STAT | x3}, 2, rx);
      st = rx[1];
   endtask

   task automatic rd(input logic [15:0] a, input int n);
      u_master.frame({CMD_RD_ARR, a[15:8], a[7:0]}, 3 + n, rx);
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d [$], input bit latch);
      logic [7:0] q [$];
      q = {CMD_WR_ARR, a[15:8], a[7:0]};
      q = {q, d};
      if (latch) u_master.frame({CMD_SET_WL}, 1, rx);
      u_master.frame(q, q.size(), rx);
   endtask

   task automatic wrst(input logic [7:0] v);
      u_master.frame({CMD_SET_WL}, 1, rx);
      u_master.frame({CMD_WR_STAT, v}, 2, rx);
   endtask

   // A refused command leaves the latch as it was, so it is cleared before the check.
   task automatic finish_write(input logic [7:0] exp, input bit busy_exp);
      chk("busy_out", {7'h00, busy_out}, {7'h00, busy_exp});
      if (!busy_exp) u_master.frame({CMD_CLR_WL}, 1, rx);
      rd_status();
      if (busy_exp) chk("status busy", st, ST_ALL_ONES);
      for (int i = 0; i < 20 && st[ST_BUSY] !== 1'b0; i++) rd_status();
      chk("status after", st, exp);
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge clk_sys);
      n_fail++;
      report_and_stop();
   end

   // ==========================================
   // Test sequence.
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rd_status();
      chk("status reset", st, 8'h00);
      for (int b = 0; b < 2; b++) begin
         u_master.frame({CMD_SET_WL | 8'(b * 8)}, 1, rx);
         rd_status(8'(b * 8));
         chk("latch set", st, 8'h02);
         u_master.frame({CMD_CLR_WL | 8'(b * 8)}, 1, rx);
         rd_status(8'(b * 8));
         chk("latch clear", st, 8'h00);
      end
      wr(16'h0000, {8'h11}, 1'b1);
      finish_write(8'h00, 1'b1);
      wr(16'h0000, {8'hA5}, 1'b0);
      finish_write(8'h00, 1'b0);
      wr(16'h0001, {8'h44}, 1'b1);
      wr(16'h0000, {8'h99}, 1'b0);
      finish_write(8'h00, 1'b1);
      rd(16'h0000, 2);
      chk("rd 0", rx[3], 8'h11);
      chk("rd 1", rx[4], 8'h44);
      chk("oe read", {7'h00, oe_seen}, 8'h01);
      for (int i = 0; i < 65; i++) dq.push_back(8'(i));
      wr(16'hC17F, dq, 1'b1);
      finish_write(8'h00, 1'b1);
      rd(16'h017E, 2);
      chk("page 7E", rx[3], 8'h3F);
      chk("page 7F", rx[4], 8'h40);
      rd(16'h0140, 1);
      chk("page 40", rx[3], 8'h01);
      wr(16'h3FFF, {8'h5A}, 1'b1);
      finish_write(8'h00, 1'b1);
      rd(16'h3FFF, 2);
      chk("wrap top", rx[3], 8'h5A);
      chk("wrap zero", rx[4], 8'h11);
      wr(16'h3000, {8'h30}, 1'b1);
      finish_write(8'h00, 1'b1);
      wr(16'h2000, {8'h20}, 1'b1);
      finish_write(8'h00, 1'b1);
      for (int lvl = 1; lvl <= 3; lvl++) begin
         wrst({4'h0, 2'(lvl), 2'b00});
         finish_write({4'h0, 2'(lvl), 2'b00}, 1'b1);
         wr(prot[lvl], {8'hC0}, 1'b1);
         finish_write({4'h0, 2'(lvl), 2'b00}, 1'b0);
         rd(prot[lvl], 1);
         chk("protected", rx[3], old[lvl]);
         if (lvl < 3) begin
            wr(prot[lvl] - 16'h0001, {8'(8'h70 + lvl)}, 1'b1);
            finish_write({4'h0, 2'(lvl), 2'b00}, 1'b1);
            rd(prot[lvl] - 16'h0001, 1);
            chk("unprotected", rx[3], 8'(8'h70 + lvl));
         end
      end
      wrst(8'h80);
      finish_write(8'h80, 1'b1);
      wp_n <= 1'b0;
      wrst(8'h00);
      finish_write(8'h80, 1'b0);
      wr(16'h0002, {8'h66}, 1'b1);
      finish_write(8'h80, 1'b1);
      rd(16'h0002, 1);
      chk("hw free write", rx[3], 8'h66);
      wp_n <= 1'b1;
      wrst(8'h00);
      finish_write(8'h00, 1'b1);
      wp_n <= 1'b0;
      wrst(8'h04);
      finish_write(8'h04, 1'b1);
      wp_n <= 1'b1;
      u_master.frame({8'hFF, CMD_RD_STAT}, 3, rx);
      chk("bad opcode oe", {7'h00, oe_seen}, 8'h00);
      report_and_stop();
   end
endmodule
